// file: core/watchdog_timer_pkg.sv
package watchdog_timer_pkg;

    // =========================================================
    // register map (byte addresses, one 32-bit word each)
    localparam int          ADDR_W         = 8;
    localparam logic [7:0]  OFS_RELOAD     = 8'h00;
    localparam logic [7:0]  OFS_COUNT      = 8'h04;
    localparam logic [7:0]  OFS_CTRL       = 8'h08;
    localparam logic [7:0]  OFS_INT_CLEAR  = 8'h0C;
    localparam logic [7:0]  OFS_RAW_STAT   = 8'h10;
    localparam logic [7:0]  OFS_MASK_STAT  = 8'h14;
    localparam logic [7:0]  OFS_LOCK       = 8'h18;
    localparam logic [7:0]  OFS_DEBUG      = 8'h1C;

    // =========================================================
    // control word and debug word fields
    localparam int          CTRL_RUN_BIT   = 0;
    localparam int          CTRL_IEN_BIT   = 1;
    localparam int          CTRL_RSTEN_BIT = 2;
    localparam int          DEBUG_STALL_BIT = 0;

    // =========================================================
    // lock key and reset values
    // unlock key value is arbitrary
    localparam logic [31:0] UNLOCK_KEY     = 32'hC3A5965A;
    localparam logic [31:0] RELOAD_RESET   = 32'hFFFFFFFF;
    localparam logic [31:0] READ_UNMAPPED  = 32'h00000000;

    typedef struct packed {
        logic run;
        logic intEn;
        logic rstEn;
    } ctrl_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FIRST,
        ST_SECOND
    } wd_state_t;

endpackage : watchdog_timer_pkg

// file: core/watchdog_timer.sv
// How it works
// - reload write loads counter at once when running
// - writing reload zero raises interrupt immediately
// - lock blocks reload, enable and reset writes
// - key releases lock, other lock write engages
// - reset on second timeout only if enabled
// - enable state readable in control word
// - debug stall freezes count while halted
// - without stall, counting ignores halt
// - live counter value readable any time
// - 32-bit down count, timeout, reload, continue
// - second zero with pending interrupt resets system
// - enabling counter also enables interrupt
// - raw and masked interrupt status readable
module watchdog_timer #(
    parameter int CNT_W = 32
) (
    input  wire logic                                   mclk,
    input  wire logic                                   reset_n,
    input  wire logic [watchdog_timer_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [31:0]                            regWdata,
    input  wire logic                                   regWr,
    input  wire logic                                   regRd,
    output logic      [31:0]                            regRdata,
    input  wire logic                                   cpuHalted,
    output logic                                        wdIrq,
    output logic                                        sysReset
);

    // =========================================================
    // register state
    logic [CNT_W-1:0]          reload_q;
    logic [CNT_W-1:0]          count_q;
    watchdog_timer_pkg::ctrl_t ctrl_q;
    logic                      locked_q;
    logic                      stall_q;
    logic                      rawInt_q;
    logic                      haltS1_q;
    logic                      halted_q;

    // =========================================================
    // decoded strobes and events
    logic                      wrReload;
    logic                      wrCtrl;
    logic                      wrClear;
    logic                      wrLock;
    logic                      wrDebug;
    logic                      startRun;
    logic                      zeroReload;
    logic                      ticking;
    logic                      atZero;
    logic                      expired;
    logic                      rawNext;
    logic                      intEnNext;
    logic [31:0]               rdataMux;

    // =========================================================
    // write decode
    always_comb begin
        wrReload = 1'b0;
        wrCtrl   = 1'b0;
        wrClear  = 1'b0;
        wrLock   = 1'b0;
        wrDebug  = 1'b0;
        if (regWr) begin
            case (regAddr)
                watchdog_timer_pkg::OFS_RELOAD: begin
                    wrReload = !locked_q;
                end
                watchdog_timer_pkg::OFS_CTRL: begin
                    wrCtrl = !locked_q;
                end
                watchdog_timer_pkg::OFS_INT_CLEAR: begin
                    wrClear = 1'b1;
                end
                watchdog_timer_pkg::OFS_LOCK: begin
                    wrLock = 1'b1;
                end
                watchdog_timer_pkg::OFS_DEBUG: begin
                    wrDebug = 1'b1;
                end
                default: begin
                    // unmapped writes are dropped
                    wrClear = 1'b0;
                end
            endcase
        end
    end

    // halt input comes from the debug domain
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            haltS1_q <= 1'b0;
            halted_q <= 1'b0;
        end else begin
            haltS1_q <= cpuHalted;
            halted_q <= haltS1_q;
        end
    end

    // =========================================================
    // count events
    assign ticking    = ctrl_q.run && !(stall_q && halted_q);
    assign atZero     = count_q == '0;
    assign expired    = ticking && atZero;
    assign zeroReload = wrReload && regWdata[CNT_W-1:0] == '0;
    assign startRun   = wrCtrl && !ctrl_q.run && regWdata[watchdog_timer_pkg::CTRL_RUN_BIT];

    // next raw and enable state, so the pin follows the masked status exactly
    assign rawNext   = expired || zeroReload || (rawInt_q && !wrClear);
    assign intEnNext = ctrl_q.intEn || (wrCtrl && (regWdata[watchdog_timer_pkg::CTRL_IEN_BIT]
                       || regWdata[watchdog_timer_pkg::CTRL_RUN_BIT]));

    // =========================================================
    // reload value
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reload_q <= CNT_W'(watchdog_timer_pkg::RELOAD_RESET);
        end else if (wrReload) begin
            reload_q <= regWdata[CNT_W-1:0];
        end
    end

    // =========================================================
    // control word
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= '0;
        end else if (wrCtrl) begin
            // run and interrupt enable are sticky once set
            ctrl_q.run   <= ctrl_q.run | regWdata[watchdog_timer_pkg::CTRL_RUN_BIT];
            ctrl_q.intEn <= intEnNext;
            ctrl_q.rstEn <= regWdata[watchdog_timer_pkg::CTRL_RSTEN_BIT];
        end
    end

    // =========================================================
    // debug stall
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stall_q <= 1'b0;
        end else if (wrDebug) begin
            stall_q <= regWdata[watchdog_timer_pkg::DEBUG_STALL_BIT];
        end
    end

    // =========================================================
    // lock
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            locked_q <= 1'b0;
        end else if (wrLock) begin
            locked_q <= regWdata != watchdog_timer_pkg::UNLOCK_KEY;
        end
    end

    // =========================================================
    // counter
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= CNT_W'(watchdog_timer_pkg::RELOAD_RESET);
        end else if (wrReload && ctrl_q.run) begin
            count_q <= regWdata[CNT_W-1:0];
        end else if (startRun) begin
            count_q <= reload_q;
        end else if (ticking) begin
            if (atZero || (wrClear && rawInt_q)) begin
                count_q <= reload_q;
            end else begin
                count_q <= count_q - CNT_W'(1);
            end
        end
    end

    // =========================================================
    // timeout interrupt and reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rawInt_q <= 1'b0;
        end else begin
            rawInt_q <= rawNext;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wdIrq <= 1'b0;
        end else begin
            wdIrq <= rawNext && intEnNext;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sysReset <= 1'b0;
        end else if (expired && rawInt_q && ctrl_q.rstEn) begin
            sysReset <= 1'b1;
        end
    end

    // =========================================================
    // read port
    always_comb begin
        rdataMux = watchdog_timer_pkg::READ_UNMAPPED;
        case (regAddr)
            watchdog_timer_pkg::OFS_RELOAD:    rdataMux = 32'(reload_q);
            watchdog_timer_pkg::OFS_COUNT:     rdataMux = 32'(count_q);
            watchdog_timer_pkg::OFS_CTRL:      rdataMux = {29'h0, ctrl_q.rstEn,
                                                           ctrl_q.intEn, ctrl_q.run};
            watchdog_timer_pkg::OFS_RAW_STAT:  rdataMux = {31'h0, rawInt_q};
            watchdog_timer_pkg::OFS_MASK_STAT: rdataMux = {31'h0, rawInt_q & ctrl_q.intEn};
            watchdog_timer_pkg::OFS_LOCK:      rdataMux = {31'h0, locked_q};
            watchdog_timer_pkg::OFS_DEBUG:     rdataMux = {31'h0, stall_q};
            default:                           rdataMux = watchdog_timer_pkg::READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            regRdata <= '0;
        end else if (regRd) begin
            regRdata <= rdataMux;
        end else begin
            regRdata <= '0;
        end
    end

endmodule : watchdog_timer

// file: tb/watchdog_timer_properties.sv
module watchdog_timer_properties (
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    input wire logic        wdIrq,
    input wire logic        sysReset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    logic lock_q;
    // =========================
    // lock state as software left it
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lock_q <= 1'b0;
        end else if (regWr && regAddr == watchdog_timer_pkg::OFS_LOCK) begin
            lock_q <= regWdata != watchdog_timer_pkg::UNLOCK_KEY;
        end
    end
    // =========================
    // properties
    AST_QUIET: assert property (disable iff (1'b0) !reset_n |-> !wdIrq && !sysReset)
        else $error("output active in reset");
    AST_STICKY: assert property (sysReset |=> sysReset) else $error("reset dropped");
    AST_CAUSE: assert property ($rose(sysReset) |-> $past(wdIrq))
        else $error("reset without pending irq");
    AST_IDLE: assert property (!regRd |=> regRdata == 32'h0) else $error("data not idle");
    AST_MASK: assert property (regRd && regAddr == watchdog_timer_pkg::OFS_MASK_STAT
        |=> regRdata == {31'h0, $past(wdIrq)}) else $error("masked status");
    AST_LOCK: assert property (regRd && regAddr == watchdog_timer_pkg::OFS_LOCK
        |=> regRdata == {31'h0, $past(lock_q)}) else $error("lock state");
    AST_ZERO: assert property ((regWr && regAddr == watchdog_timer_pkg::OFS_RELOAD && !lock_q
        && regWdata == 32'h0) ##1 (regRd && regAddr == watchdog_timer_pkg::OFS_RAW_STAT)
        |=> regRdata[0]) else $error("zero reload gave no irq");
    AST_RUN: assert property ((regWr && regAddr == watchdog_timer_pkg::OFS_CTRL && !lock_q
        && regWdata[0]) ##1 (regRd && regAddr == watchdog_timer_pkg::OFS_CTRL)
        |=> regRdata[1:0] == 2'h3) else $error("run without irq enable");
    cover property ($rose(sysReset));
    cover property ($rose(wdIrq));
    cover property (regWr && lock_q);
endmodule : watchdog_timer_properties

// file: tb/watchdog_timer_tb_top.sv
module watchdog_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic        cpuHalted = 1'b0;
    logic        rdSeen = 1'b0;
    logic [31:0] regRdata;
    logic        wdIrq;
    logic        sysReset;
    logic [31:0] rel;
    logic [31:0] expQ[$];
    logic [31:0] slackQ[$];
    int          n_errors = 0;
    int          total_checks = 0;
    watchdog_timer dut (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cpuHalted(cpuHalted),
        .wdIrq(wdIrq), .sysReset(sysReset));
    initial begin
        forever #2 mclk = ~mclk;
    end
    task automatic chk(input string what, input logic [31:0] e, got, s);
        total_checks++;
        if (((got <= e) && (e - got <= s)) !== 1'b1) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, e, got);
        end
    endtask : chk
    task automatic bus(input logic w, r, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regWr <= w;
        regRd <= r;
        regAddr <= a;
        regWdata <= d;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e, s);
        expQ.push_back(e);
        slackQ.push_back(s);
        bus(1'b0, 1'b1, a, 32'h0);
    endtask : rd
    task automatic complete_run();
        if (n_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    // =========================
    // read data checker and watchdog
    always @(posedge mclk) rdSeen <= regRd;
    always @(negedge mclk) begin
        if (rdSeen) chk("regRdata", expQ.pop_front(), regRdata, slackQ.pop_front());
    end
    initial begin
        #20000;
        n_errors++;
        complete_run();
    end
    initial begin
        void'($urandom(39643));
        rel = 32'h100 + ($urandom % 32'h100);
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        rd(watchdog_timer_pkg::OFS_CTRL, 32'h0, 32'h0);
        rd(watchdog_timer_pkg::OFS_COUNT, watchdog_timer_pkg::RELOAD_RESET, 32'h0);
        rd(8'h20, 32'h0, 32'h0);
        bus(1'b1, 1'b0, watchdog_timer_pkg::OFS_LOCK, rel);
        bus(1'b1, 1'b0, watchdog_timer_pkg::OFS_CTRL, 32'h7);
        bus(1'b1, 1'b0, watchdog_timer_pkg::OFS_RELOAD, 32'h0);
        rd(watchdog_timer_pkg::OFS_CTRL, 32'h0, 32'h0);
        rd(watchdog_timer_pkg::OFS_RAW_STAT, 32'h0, 32'h0);
        rd(watchdog_timer_pkg::OFS_LOCK, 32'h1, 32'h0);
        bus(1'b1, 1'b0, watchdog_timer_pkg::OFS_LOCK, watchdog_timer_pkg::UNLOCK_KEY);
        bus(1'b1, 1'b0, watchdog_timer_pkg::OFS_RELOAD, rel);
        bus(1'b1, 1'b0, watchdog_timer_pkg::OFS_CTRL, 32'h1);
        rd(watchdog_timer_pkg::OFS_CTRL, 32'h3, 32'h0);
        rd(watchdog_timer_pkg::OFS_COUNT, rel, 32'h3);
        bus(1'b1, 1'b0, watchdog_timer_pkg::OFS_DEBUG, 32'h1);
        cpuHalted <= 1'b1;
        repeat (6) bus(1'b0, 1'b0, 8'h00, 32'h0);
        bus(1'b1, 1'b0, watchdog_timer_pkg::OFS_RELOAD, rel);
        repeat (20) bus(1'b0, 1'b0, 8'h00, 32'h0);
        rd(watchdog_timer_pkg::OFS_COUNT, rel, 32'h0);
        bus(1'b1, 1'b0, watchdog_timer_pkg::OFS_DEBUG, 32'h0);
        bus(1'b1, 1'b0, watchdog_timer_pkg::OFS_RELOAD, rel);
        repeat (19) bus(1'b0, 1'b0, 8'h00, 32'h0);
        rd(watchdog_timer_pkg::OFS_COUNT, rel - 32'h12, 32'h2);
        cpuHalted <= 1'b0;
        bus(1'b1, 1'b0, watchdog_timer_pkg::OFS_RELOAD, 32'h20);
        repeat (40) bus(1'b0, 1'b0, 8'h00, 32'h0);
        rd(watchdog_timer_pkg::OFS_RAW_STAT, 32'h1, 32'h0);
        rd(watchdog_timer_pkg::OFS_MASK_STAT, 32'h1, 32'h0);
        @(negedge mclk);
        chk("wdIrq", 32'h1, {31'h0, wdIrq}, 32'h0);
        bus(1'b1, 1'b0, watchdog_timer_pkg::OFS_INT_CLEAR, 32'h0);
        rd(watchdog_timer_pkg::OFS_RAW_STAT, 32'h0, 32'h0);
        @(negedge mclk);
        chk("wdIrq", 32'h0, {31'h0, wdIrq}, 32'h0);
        rd(watchdog_timer_pkg::OFS_COUNT, 32'h20, 32'h2);
        bus(1'b1, 1'b0, watchdog_timer_pkg::OFS_RELOAD, 32'h0);
        rd(watchdog_timer_pkg::OFS_RAW_STAT, 32'h1, 32'h0);
        bus(1'b1, 1'b0, watchdog_timer_pkg::OFS_RELOAD, 32'h10);
        repeat (60) bus(1'b0, 1'b0, 8'h00, 32'h0);
        @(negedge mclk);
        chk("sysReset", 32'h0, {31'h0, sysReset}, 32'h0);
        bus(1'b1, 1'b0, watchdog_timer_pkg::OFS_CTRL, 32'h5);
        repeat (40) bus(1'b0, 1'b0, 8'h00, 32'h0);
        @(negedge mclk);
        chk("sysReset", 32'h1, {31'h0, sysReset}, 32'h0);
        complete_run();
    end
endmodule : watchdog_timer_tb_top
bind watchdog_timer watchdog_timer_properties props (.mclk(mclk), .reset_n(reset_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .wdIrq(wdIrq), .sysReset(sysReset));
